/* File: verilog/hpfo_pkg.sv */
// package for the host port and frame input offset block
// assumes one 100 MHz system clock; all pins already synchronous to it
package hpfo_pkg;
	// host address map
	localparam logic [7:0] OFS_ADDR = 8'h00;
	localparam logic [7:0] MODE_BASE = 8'h20;
	localparam int MODE_DEPTH = 32;
	localparam int MODE_AW = 5;
	// frame input offset field
	localparam int OFS_HI = 7;
	localparam int OFS_LO = 5;
	localparam logic [2:0] OFS_RST = 3'h0;
	localparam logic [2:0] OFS_MAX = 3'h4;
	localparam logic [7:0] DATA_RST = 8'h00;
	// bit counter: 8 bits per channel, 32 channels
	localparam int BIT_W = 8;
	localparam int CH_LO = 3;

	// host access state, one-hot
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_ACK = 3'b100
	} hpfo_state_e;

	// host bus pins as seen by the device
	typedef struct packed
	{
		logic ale;
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic [7:0] ad;
	} hpfo_bus_s;
endpackage

/* File: verilog/hpfo_top.sv */
// host port with access stretching, frame input offset, delay mode bits
// assumes the host keeps strobes and write data steady until acknowledge
`timescale 1ns/1ps
module hpfo_top
	import hpfo_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// host port
	input wire hpfo_bus_s bus,
	output logic [7:0] ad_o,
	output logic ad_oe,
	output logic ack_n,
	// serial timing
	input wire logic bclk,
	input wire logic fp_n,
	output logic frame_start,
	output logic const_delay
);
	hpfo_state_e st_q;
	logic [7:0] addr_q;
	logic ale_prev_q;
	logic bclk_prev_q;
	logic fp_prev_q;
	logic [2:0] ofs_q;
	logic [2:0] cnt_q;
	logic [BIT_W-1:0] bit_q;
	logic [MODE_DEPTH-1:0] mode_q;
	logic [7:0] ad_o_q;
	logic ad_oe_q;
	logic ack_n_q;
	logic frame_start_q;
	logic const_delay_q;
	logic ale_fall;
	logic bclk_rise;
	logic fp_edge;
	logic req;
	logic release_bus;
	logic commit;
	logic is_mode;
	logic [MODE_AW-1:0] mode_idx;
	logic [2:0] ofs_eff;
	logic [7:0] rd_data;

	// edge detectors and decode
	assign ale_fall = ale_prev_q & ~bus.ale;
	assign bclk_rise = bclk & ~bclk_prev_q;
	assign fp_edge = bclk_rise & ~fp_n & fp_prev_q;
	assign req = ~bus.cs_n & (~bus.rd_n | ~bus.wr_n);
	assign release_bus = bus.cs_n | (bus.rd_n & bus.wr_n);
	assign commit = (st_q == ST_WAIT) & ~bclk_rise;
	assign is_mode = (addr_q[7:MODE_AW] == MODE_BASE[7:MODE_AW]);
	assign mode_idx = addr_q[MODE_AW-1:0];
	assign ofs_eff = (ofs_q > OFS_MAX) ? 3'h0 : ofs_q;
	assign rd_data = (addr_q == OFS_ADDR) ? {ofs_q, 5'h00} :
		is_mode ? {7'h00, mode_q[mode_idx]} : DATA_RST;

	// previous pin levels
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			ale_prev_q <= 1'b0;
			bclk_prev_q <= 1'b0;
			fp_prev_q <= 1'b1;
		end
		else
		begin
			ale_prev_q <= bus.ale;
			bclk_prev_q <= bclk;
			if (bclk_rise)
				fp_prev_q <= fp_n;
		end
	end

	// address latch
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			addr_q <= 8'h00;
		else if (ale_fall)
			addr_q <= bus.ad;
	end

	// host access sequencer
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			st_q <= ST_IDLE;
			ack_n_q <= 1'b1;
			ad_oe_q <= 1'b0;
			ad_o_q <= DATA_RST;
		end
		else
		begin
			case (st_q)
				ST_IDLE:
				begin
					if (req)
						st_q <= ST_WAIT;
				end
				ST_WAIT:
				begin
					if (commit)
					begin
						st_q <= ST_ACK;
						ack_n_q <= 1'b0;
						ad_oe_q <= ~bus.rd_n;
						ad_o_q <= rd_data;
					end
				end
				ST_ACK:
				begin
					if (release_bus)
					begin
						st_q <= ST_IDLE;
						ack_n_q <= 1'b1;
						ad_oe_q <= 1'b0;
					end
				end
				default:
				begin
					st_q <= ST_IDLE;
					ack_n_q <= 1'b1;
					ad_oe_q <= 1'b0;
				end
			endcase
		end
	end

	// offset register, only bits 7-5 stored
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			ofs_q <= OFS_RST;
		else if (commit && !bus.wr_n && addr_q == OFS_ADDR)
			ofs_q <= bus.ad[OFS_HI:OFS_LO];
	end

	// per-channel delay mode bits
	genvar gi;
	generate
		for (gi = 0; gi < MODE_DEPTH; gi++)
		begin : g_mode
			always_ff @(posedge clk_sys)
			begin
				if (!rst_n)
					mode_q[gi] <= 1'b0;
				else if (commit && !bus.wr_n && is_mode && mode_idx == gi)
					mode_q[gi] <= bus.ad[0];
			end
		end
	endgenerate

	// frame start after offset bit clocks
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			cnt_q <= 3'h0;
			frame_start_q <= 1'b0;
		end
		else
		begin
			frame_start_q <= 1'b0;
			if (fp_edge && ofs_eff == 3'h0)
				frame_start_q <= 1'b1;
			else if (fp_edge)
				cnt_q <= ofs_eff;
			else if (bclk_rise && cnt_q != 3'h0)
			begin
				cnt_q <= cnt_q - 3'h1;
				frame_start_q <= (cnt_q == 3'h1);
			end
		end
	end

	// bit position and current channel delay mode
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			bit_q <= '0;
			const_delay_q <= 1'b0;
		end
		else
		begin
			if (frame_start_q)
				bit_q <= '0;
			else if (bclk_rise)
				bit_q <= bit_q + 8'h01;
			const_delay_q <= mode_q[bit_q[BIT_W-1:CH_LO]];
		end
	end

	assign ad_o = ad_o_q;
	assign ad_oe = ad_oe_q;
	assign ack_n = ack_n_q;
	assign frame_start = frame_start_q;
	assign const_delay = const_delay_q;

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	addr_latch_a: assert property (ale_fall |=> addr_q == $past(bus.ad))
		else $error("address not latched on ale fall");
	ack_state_a: assert property (!ack_n_q |-> st_q == ST_ACK)
		else $error("acknowledge outside ack state");
	stall_hold_a: assert property (st_q == ST_WAIT && bclk_rise |=> ack_n_q)
		else $error("acknowledge during contention");
	ack_bound_a: assert property (st_q == ST_WAIT |-> ##[1:2] !ack_n_q)
		else $error("access stretched too long");
	ack_hold_a: assert property (!ack_n_q && !release_bus |=> !ack_n_q)
		else $error("acknowledge dropped before release");
	ofs_write_a: assert property (commit && !bus.wr_n && addr_q == OFS_ADDR
		|=> ofs_q == $past(bus.ad[OFS_HI:OFS_LO]))
		else $error("offset write lost");
	read_low_a: assert property (!ack_n_q && ad_oe_q && addr_q == OFS_ADDR
		|-> ad_o_q[4:0] == 5'h00)
		else $error("offset low bits not zero");
	zero_ofs_a: assert property (fp_edge && ofs_eff == 3'h0 |=> frame_start_q)
		else $error("no frame start at zero offset");
	ofs_end_a: assert property (!fp_edge && bclk_rise && cnt_q == 3'h1
		|=> frame_start_q && cnt_q == 3'h0)
		else $error("offset count end missed");
	mode_sel_a: assert property (1'b1
		|=> const_delay_q == $past(mode_q[bit_q[BIT_W-1:CH_LO]]))
		else $error("delay mode not from channel bit");

	write_c: cover property (commit && !bus.wr_n);
	read_c: cover property (commit && !bus.rd_n);
	stall_c: cover property (st_q == ST_WAIT && bclk_rise);
	ofs4_c: cover property (fp_edge && ofs_eff == OFS_MAX);
endmodule

/* File: tb/hpfo_host.sv */
// host model: controller with glue latches on the device port
// assumes the bench calls wr and rd one at a time
`timescale 1ns/1ps
module hpfo_host
	import hpfo_pkg::*;
(
	// device side
	input wire logic clk_sys,
	input wire logic [7:0] ad_o,
	input wire logic ad_oe,
	input wire logic ack_n,
	output hpfo_bus_s bus,
	// wait bound used up
	output logic to
);
	initial bus = '{1'b0, 1'b1, 1'b1, 1'b1, 8'h00};
	initial to = 1'b0;
	// one access, strobes held until acknowledge
	task automatic acc(input logic w, input logic [7:0] a, d,
		output logic [7:0] q);
		int n;
		@(posedge clk_sys);
		bus.ale <= 1'b1;
		bus.ad <= a;
		@(posedge clk_sys);
		bus.ale <= 1'b0;
		@(posedge clk_sys);
		bus.cs_n <= 1'b0;
		bus.rd_n <= w;
		bus.wr_n <= !w;
		bus.ad <= w ? d : ~a;
		for (n = 0; n < 40 && ack_n !== 1'b0; n++)
			@(posedge clk_sys);
		if (n == 40)
			to = 1'b1;
		q = (ad_oe === 1'b1) ? ad_o : ~ad_o;
		bus.cs_n <= 1'b1;
		bus.rd_n <= 1'b1;
		bus.wr_n <= 1'b1;
		bus.ad <= ~bus.ad;
	endtask
	// single write per update
	task automatic wr(input logic [7:0] a, d);
		logic [7:0] q;
		acc(1'b1, a, d, q);
	endtask
	// two reads, second kept
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		acc(1'b0, a, 8'h00, q);
		acc(1'b0, a, 8'h00, q);
	endtask
endmodule

/* File: tb/hpfo_top_test.sv */
// bench for the host port and frame input offset block
// assumes the host model makes every port access
`timescale 1ns/1ps
module hpfo_top_test
	import hpfo_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic bclk = 1'b0;
	logic fp_n = 1'b1;
	logic [3:0] ph = 4'h0;
	int nr = 0;
	int err_count = 0;
	int check_count = 0;
	hpfo_bus_s bus;
	logic [7:0] ad_o;
	logic ad_oe;
	logic ack_n;
	logic frame_start;
	logic const_delay;
	logic to;
	logic [7:0] q;
	always #5 clk_sys = ~clk_sys;
	hpfo_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .ad_o(ad_o),
		.ad_oe(ad_oe), .ack_n(ack_n), .bclk(bclk), .fp_n(fp_n),
		.frame_start(frame_start), .const_delay(const_delay));
	hpfo_host H (.clk_sys(clk_sys), .ad_o(ad_o), .ad_oe(ad_oe),
		.ack_n(ack_n), .bus(bus), .to(to));
	// bit clock at a tenth of the system clock, rises counted
	always @(posedge clk_sys)
	begin
		ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
		bclk <= (ph == 4'h9) ? 1'b1 : (ph == 4'h4) ? 1'b0 : bclk;
		nr <= (ph == 4'h9) ? nr + 1 : nr;
	end
	// hung access ends the run
	always @(posedge clk_sys)
		if (to === 1'b1)
		begin
			err_count++;
			end_sim;
		end
	// compare and count
	task automatic chk(input logic [7:0] s, e);
		check_count++;
		if (s !== e)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// counts and verdict
	task automatic end_sim;
		$display("checks=%0d errors=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// set offset code, pulse frame, count bit clocks to first bit
	task automatic frm(input logic [2:0] c);
		int t0;
		int n;
		H.wr(OFS_ADDR, {c, 5'h1f});
		H.rd(OFS_ADDR, q);
		chk(q, {c, 5'h00});
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (ph != 4'h9 && n < 20);
		if (ph != 4'h9)
		begin
			err_count++;
			end_sim;
		end
		fp_n <= 1'b0;
		t0 = nr;
		for (n = 0; n < 100 && frame_start !== 1'b1; n++)
			@(posedge clk_sys);
		chk(8'(nr - t0), (c > OFS_MAX) ? 8'h01 : 8'(c + 1));
		if (n == 100)
		begin
			err_count++;
			end_sim;
		end
		fp_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk({7'h00, const_delay}, 8'h01);
		repeat (30) @(posedge clk_sys);
	endtask
	// main sequence
	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		chk({7'h00, const_delay}, 8'h00);
		H.rd(8'h10, q);
		chk(q, 8'h00);
		H.wr(MODE_BASE, 8'hff);
		H.wr(MODE_BASE + 8'h01, 8'h00);
		H.rd(MODE_BASE, q);
		chk(q, 8'h01);
		H.rd(MODE_BASE + 8'h01, q);
		chk(q, 8'h00);
		for (int i = 0; i <= 5; i++)
			frm(3'(i));
		end_sim;
	end
endmodule
